/* File: hdl/cfg_load_sequencer.sv */
// Purpose: configuration-load sequencing: clear, load, flush, init, user mode
// Assumes: all pins asynchronous to clk_sys; pull-ups on open-drain lines
// Notes:   parallel loading sampled from the host clock pin; serial loading
//          drives its own clock to the configuration memory
// Summary of operation
// - request low drops load-complete within 600 ns
// - request low pulls status low within 600 ns
// - status held low 268 to 1506 us
// - status released within 1506 us after request
// - oscillator init reaches user mode 175-437 us
// - user-clock init needs 17408 user clocks
// - quad mode moves four bits per clock
// - serial out and capture on falling edge
// - generated clock in four speed ranges
// - chained loading never uses fastest speed
// - init clock from oscillator or user pin
// - init-done held low until init ends
// - request low in user mode restarts
module cfg_load_sequencer #(
   parameter int STATUS_MIN = cfg_load_pkg::STATUS_MIN_CYC,
   parameter int STATUS_MAX = cfg_load_pkg::STATUS_MAX_CYC,
   parameter int INIT_CYC   = cfg_load_pkg::INIT_MIN_CYC,
   parameter int USER_EDGES = cfg_load_pkg::USER_INIT_EDGES,
   parameter int CFG_WORDS  = 1024
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        config_req_n,
   input  wire logic        status_in,
   output wire logic        status_out,
   output wire logic        status_oe,
   output wire logic        load_complete,
   output wire logic        init_done_out,
   output wire logic        init_done_oe,
   output wire logic        user_mode,
   input  wire logic [1:0]  load_mode,
   input  wire logic [3:0]  ratio,
   input  wire logic        init_from_user_clk,
   input  wire logic        init_done_enable,
   input  wire logic        chain_mode,
   input  wire logic [1:0]  as_speed,
   input  wire logic        user_clock,
   input  wire logic        load_clock_in,
   output wire logic        load_clock_out,
   output wire logic        load_clock_oe,
   input  wire logic [31:0] load_data,
   output wire logic        memory_select_n,
   output wire logic        serial_data_line0,
   output wire logic        serial_data_line0_oe,
   input  wire logic [3:0]  quad_serial_data,
   output wire logic [31:0] out_data,
   output wire logic        out_valid,
   input  wire logic        out_ready,
   output wire logic        overrun
);
   localparam int W  = cfg_load_pkg::WORD_W;
   localparam int PW = W + 19;

   if (STATUS_MIN < 1 || STATUS_MIN >= 2 ** 18 || INIT_CYC < 1 || USER_EDGES < 1 ||
       INIT_CYC > cfg_load_pkg::INIT_MAX_CYC || USER_EDGES >= 2 ** 18 ||
       STATUS_MAX < STATUS_MIN || CFG_WORDS < 1) begin : g_bad
      $error("cfg_load_sequencer: parameter out of range");
   end

   //------------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------------
   logic [PW-1:0] pin_s1_q;
   logic [PW-1:0] pin_s2_q;
   logic          lclk_d_q;
   logic          uclk_d_q;
   wire  [PW-1:0] pin_raw = {config_req_n, status_in, load_clock_in, user_clock,
                             quad_serial_data, load_mode, ratio, init_from_user_clk,
                             init_done_enable, chain_mode, as_speed, load_data};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         lclk_d_q <= 1'b0;
         uclk_d_q <= 1'b0;
      end else if (ce) begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         lclk_d_q <= pin_s2_q[W+16];
         uclk_d_q <= pin_s2_q[W+15];
      end
   end

   wire          req_s     = pin_s2_q[W+18];
   wire          status_s  = pin_s2_q[W+17];
   wire          lclk_s    = pin_s2_q[W+16];
   wire          uclk_s    = pin_s2_q[W+15];
   wire [3:0]    quad_s    = pin_s2_q[W+14:W+11];
   wire [1:0]    mode_s    = pin_s2_q[W+10:W+9];
   wire [3:0]    ratio_s   = pin_s2_q[W+8:W+5];
   wire          uinit_s   = pin_s2_q[W+4];
   wire          opt_s     = pin_s2_q[W+3];
   wire          chain_s   = pin_s2_q[W+2];
   wire [1:0]    speed_s   = pin_s2_q[W+1:W];
   wire [W-1:0]  data_s    = pin_s2_q[W-1:0];
   wire          lclk_rise = lclk_s && !lclk_d_q;
   wire          lclk_fall = !lclk_s && lclk_d_q;
   wire          uclk_rise = uclk_s && !uclk_d_q;

   //------------------------------------------------------------------
   // options latched while clearing
   //------------------------------------------------------------------
   cfg_load_pkg::seq_state_t state_q;
   cfg_load_pkg::seq_state_t state_d;
   cfg_load_pkg::load_mode_t mode_q;
   logic [3:0]   ratio_q;
   logic         uinit_q;
   logic         opt_q;
   logic         chain_q;
   logic [3:0]   half_q;

   wire [1:0] speed_eff = (chain_s && speed_s == cfg_load_pkg::AS_SPEED_TOP) ?
                          cfg_load_pkg::AS_SPEED_CHAIN : speed_s;
   wire       mode_ok   = mode_s != 2'h3;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_q  <= cfg_load_pkg::MODE_FPP;
         ratio_q <= 4'h1;
         uinit_q <= 1'b0;
         opt_q   <= 1'b0;
         chain_q <= 1'b0;
         half_q  <= 4'h1;
      end else if (ce && state_q == cfg_load_pkg::ST_CLEAR) begin
         mode_q  <= mode_ok ? cfg_load_pkg::load_mode_t'(mode_s) : cfg_load_pkg::MODE_FPP;
         ratio_q <= (ratio_s == 4'h0) ? 4'h1 : ratio_s;
         uinit_q <= uinit_s;
         opt_q   <= opt_s;
         chain_q <= chain_s;
         half_q  <= cfg_load_pkg::as_half(speed_eff);
      end
   end

   //------------------------------------------------------------------
   // sequence
   //------------------------------------------------------------------
   logic [17:0]  cnt_q;
   logic [31:0]  words_q;
   logic [1:0]   flush_q;
   logic [3:0]   phase_q;
   logic         push;
   wire          as_mode  = mode_q != cfg_load_pkg::MODE_FPP;
   wire          x4       = mode_q == cfg_load_pkg::MODE_AS_X4;
   wire          in_load  = state_q == cfg_load_pkg::ST_LOAD;
   wire          in_flush = state_q == cfg_load_pkg::ST_FLUSH;
   wire          in_init  = state_q == cfg_load_pkg::ST_INIT;
   wire          gen_fall;
   wire          fall_ev  = as_mode ? gen_fall : lclk_fall;
   wire          last_push = push && words_q == 32'(CFG_WORDS - 1);
   wire          init_tick = uinit_q ? uclk_rise : 1'b1;
   wire [17:0]   init_last = uinit_q ? 18'(USER_EDGES - 1) : 18'(INIT_CYC - 1);
   wire          init_end  = init_tick && cnt_q == init_last;
   wire          status_ok = cnt_q >= 18'(STATUS_MIN);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         cfg_load_pkg::ST_CLEAR:
            if (status_ok && req_s) state_d = cfg_load_pkg::ST_WAIT_STATUS;
         cfg_load_pkg::ST_WAIT_STATUS:
            if (status_s) state_d = cfg_load_pkg::ST_LOAD;
         cfg_load_pkg::ST_LOAD:
            if (last_push) state_d = cfg_load_pkg::ST_FLUSH;
         cfg_load_pkg::ST_FLUSH:
            if (fall_ev && flush_q == 2'(cfg_load_pkg::FLUSH_FALLS - 1)) begin
               state_d = cfg_load_pkg::ST_INIT;
            end
         cfg_load_pkg::ST_INIT:
            if (init_end) state_d = cfg_load_pkg::ST_USER;
         cfg_load_pkg::ST_USER:
            state_d = cfg_load_pkg::ST_USER;
         default:
            state_d = cfg_load_pkg::ST_CLEAR;
      endcase
      if (!req_s) state_d = cfg_load_pkg::ST_CLEAR;
   end

   wire cnt_inc = (state_q == cfg_load_pkg::ST_CLEAR) ? !status_ok : (in_init && init_tick);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= cfg_load_pkg::ST_CLEAR;
         cnt_q   <= '0;
         flush_q <= '0;
      end else if (ce) begin
         state_q <= state_d;
         cnt_q   <= (state_d != state_q) ? 18'h0 : cnt_q + 18'(cnt_inc);
         flush_q <= !in_flush ? 2'h0 : flush_q + 2'(fall_ev);
      end
   end

   //------------------------------------------------------------------
   // parallel capture, one word per ratio clocks
   //------------------------------------------------------------------
   wire fpp_cap = !as_mode && in_load && lclk_rise && phase_q == 4'h0;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_q <= 4'h0;
      end else if (ce) begin
         if (!in_load) phase_q <= 4'h0;
         else if (lclk_rise) phase_q <= (phase_q == ratio_q - 4'h1) ? 4'h0 : phase_q + 4'h1;
      end
   end

   //------------------------------------------------------------------
   // serial engine: clock divider, command out, data in
   //------------------------------------------------------------------
   logic [3:0]   div_q;
   logic         gclk_q;
   logic [31:0]  cmd_q;
   logic [5:0]   cmd_cnt_q;
   logic [1:0]   fall_p_q;
   logic [W-1:0] sh_q;
   logic [4:0]   bits_q;
   logic         in_ready;
   // stalling the memory clock is the back-pressure path for serial loading
   wire          as_run  = as_mode && (in_flush || (in_load && in_ready)) && fall_p_q == 2'h0;
   wire          tick    = as_run && div_q == half_q - 4'h1;
   wire          cmd_done = cmd_cnt_q == 6'(cfg_load_pkg::AS_CMD_BITS);
   assign gen_fall = tick && gclk_q;
   wire [4:0]    step    = x4 ? 5'h4 : 5'h1;
   wire [W-1:0]  as_word = x4 ? {sh_q[W-5:0], quad_s} : {sh_q[W-2:0], quad_s[1]};
   wire          as_cap  = fall_p_q[1] && in_load && 5'(bits_q + step) == 5'h0;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q     <= 4'h0;
         gclk_q    <= 1'b0;
         cmd_q     <= cfg_load_pkg::AS_READ_CMD;
         cmd_cnt_q <= 6'h0;
         fall_p_q  <= 2'h0;
         bits_q    <= 5'h0;
      end else if (ce) begin
         div_q    <= !as_run ? 4'h0 : (tick ? 4'h0 : div_q + 4'h1);
         gclk_q   <= tick ? !gclk_q : (as_run ? gclk_q : 1'b0);
         fall_p_q <= {fall_p_q[0], gen_fall && in_load && cmd_done};
         if (!in_load && !in_flush) begin
            cmd_q     <= cfg_load_pkg::AS_READ_CMD;
            cmd_cnt_q <= 6'h0;
            bits_q    <= 5'h0;
         end else begin
            if (gen_fall && !cmd_done) begin
               cmd_q     <= {cmd_q[30:0], 1'b0};
               cmd_cnt_q <= cmd_cnt_q + 6'h1;
            end
            if (fall_p_q[1]) begin
               sh_q   <= as_word;
               bits_q <= bits_q + step;
            end
         end
      end
   end

   //------------------------------------------------------------------
   // word buffer
   //------------------------------------------------------------------
   logic overrun_q;
   word_stream_if #(.W(W)) buf_in ();
   word_stream_if #(.W(W)) buf_out ();

   word_buffer #(.W(W), .DEPTH(2)) u_buf (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .wr      (buf_in),
      .rd      (buf_out)
   );

   assign push          = fpp_cap || as_cap;
   assign in_ready      = buf_in.ready;
   assign buf_in.valid  = push;
   assign buf_in.data   = as_mode ? as_word : data_s;
   assign buf_out.ready = out_ready;
   assign out_data      = buf_out.data;
   assign out_valid     = buf_out.valid;

   // a parallel host cannot be stalled, so a word with no room is flagged
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         words_q   <= '0;
         overrun_q <= 1'b0;
      end else if (ce) begin
         words_q   <= !in_load ? 32'h0 : words_q + 32'(push);
         overrun_q <= (state_q == cfg_load_pkg::ST_CLEAR) ? 1'b0 :
                      (overrun_q || (fpp_cap && !in_ready));
      end
   end

   //------------------------------------------------------------------
   // pin outputs, decoded from state, option and engine flops
   //------------------------------------------------------------------
   assign status_out           = 1'b0;
   assign status_oe            = state_q == cfg_load_pkg::ST_CLEAR;
   assign load_complete        = in_flush || in_init || state_q == cfg_load_pkg::ST_USER;
   assign user_mode            = state_q == cfg_load_pkg::ST_USER;
   assign init_done_out        = 1'b0;
   assign init_done_oe         = opt_q && (in_flush || in_init);
   assign load_clock_out       = gclk_q;
   assign load_clock_oe        = as_mode && (in_load || in_flush);
   assign memory_select_n      = !(as_mode && in_load);
   assign serial_data_line0    = cmd_q[31];
   assign serial_data_line0_oe = as_mode && in_load && !cmd_done;
   assign overrun              = overrun_q;

   //------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------
   logic [17:0] low_cyc_q;
   logic [17:0] rel_cyc_q;
   logic [17:0] init_cyc_q;
   logic [17:0] uedge_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         low_cyc_q  <= '0;
         rel_cyc_q  <= '0;
         init_cyc_q <= '0;
         uedge_q    <= '0;
      end else if (ce) begin
         low_cyc_q  <= status_oe ? low_cyc_q + 18'h1 : 18'h0;
         rel_cyc_q  <= (status_oe && req_s) ? rel_cyc_q + 18'h1 : 18'h0;
         init_cyc_q <= in_init ? init_cyc_q + 18'h1 : (user_mode ? init_cyc_q : 18'h0);
         uedge_q    <= in_init ? uedge_q + 18'(uclk_rise) : (user_mode ? uedge_q : 18'h0);
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst || !ce);

   AST_REQ_DONE_LOW: assert property ($fell(req_s) |=> !load_complete [*2])
      else $error("load-complete not low after request");
   AST_REQ_STATUS_LOW: assert property ($fell(req_s) |=> status_oe)
      else $error("status not pulled low after request");
   AST_STATUS_MIN: assert property ($fell(status_oe) |-> low_cyc_q > 18'(STATUS_MIN))
      else $error("status low pulse too short");
   AST_STATUS_REL: assert property (rel_cyc_q <= 18'(STATUS_MAX))
      else $error("status not released in time");
   AST_INIT_OSC: assert property ($rose(user_mode) && !uinit_q |-> init_cyc_q == 18'(INIT_CYC))
      else $error("oscillator init length wrong");
   AST_INIT_USER: assert property ($rose(user_mode) && uinit_q |-> uedge_q == 18'(USER_EDGES))
      else $error("user clock init edge count wrong");
   AST_QUAD_RATE: assert property (fall_p_q[1] && x4 && in_load |=> bits_q == $past(bits_q) + 5'h4)
      else $error("quad mode did not take four bits");
   AST_SDO_AT_FALL: assert property ($past(serial_data_line0_oe) && serial_data_line0_oe &&
                                     $changed(serial_data_line0) |-> $fell(load_clock_out))
      else $error("serial output changed off the falling edge");
   AST_SPEED_LEGAL: assert property (chain_q |-> half_q != cfg_load_pkg::as_half(2'h3))
      else $error("fastest clock used while chained");
   AST_RESTART: assert property (user_mode && !req_s |=> !user_mode && status_oe)
      else $error("request in user mode did not restart");

   COV_FPP_LOAD: cover property (!as_mode && $rose(user_mode));
   COV_AS4_LOAD: cover property (x4 && $rose(load_complete));
   COV_RESTART: cover property (user_mode ##1 !user_mode && status_oe);
endmodule

/* File: hdl/cfg_load_pkg.sv */
// Purpose: shared constants and types of the configuration-load sequencer
// Assumes: system clock of 125 MHz
// Notes:   times kept in printed units, cycle counts derived from them
package cfg_load_pkg;
   localparam int CLK_KHZ         = 125000;
   localparam int WORD_W          = 32;
   localparam int T_REACT_NS      = 600;
   localparam int REACT_CYC       = T_REACT_NS * CLK_KHZ / 1000000;
   localparam int T_STATUS_MIN_US = 268;
   localparam int STATUS_MIN_CYC  = T_STATUS_MIN_US * CLK_KHZ / 1000;
   localparam int T_STATUS_MAX_US = 1506;
   localparam int STATUS_MAX_CYC  = T_STATUS_MAX_US * CLK_KHZ / 1000;
   localparam int T_INIT_MIN_US   = 175;
   localparam int INIT_MIN_CYC    = T_INIT_MIN_US * CLK_KHZ / 1000;
   localparam int T_INIT_MAX_US   = 437;
   localparam int INIT_MAX_CYC    = T_INIT_MAX_US * CLK_KHZ / 1000;
   localparam int USER_INIT_EDGES = 17408;
   localparam int FLUSH_FALLS     = 2;
   localparam int AS_CMD_BITS     = 32;
   localparam logic [31:0] AS_READ_CMD    = 32'h0300_0000;
   localparam int          AS_FMAX_KHZ[4] = '{12500, 25000, 50000, 100000};
   localparam logic [1:0]  AS_SPEED_TOP   = 2'h3;
   localparam logic [1:0]  AS_SPEED_CHAIN = 2'h2;

   typedef enum logic [1:0] {
      MODE_FPP   = 2'b00,
      MODE_AS_X1 = 2'b01,
      MODE_AS_X4 = 2'b10
   } load_mode_t;

   typedef enum logic [2:0] {
      ST_CLEAR       = 3'b000,
      ST_WAIT_STATUS = 3'b001,
      ST_LOAD        = 3'b010,
      ST_FLUSH       = 3'b011,
      ST_INIT        = 3'b100,
      ST_USER        = 3'b101
   } seq_state_t;

   // half period in system cycles, rounded up so the range maximum holds
   function automatic logic [3:0] as_half(input logic [1:0] sel);
      int f;
      f = AS_FMAX_KHZ[sel];
      return 4'((CLK_KHZ + 2 * f - 1) / (2 * f));
   endfunction
endpackage

/* File: hdl/word_stream_if.sv */
// Purpose: valid/ready word carrier between sequencer and its buffer
// Assumes: both ends on clk_sys
// Notes:   transfer when valid and ready are both high
interface word_stream_if #(parameter int W = 32) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: hdl/word_buffer.sv */
// Purpose: small FIFO between word capture and the word consumer
// Assumes: DEPTH a power of two, at least two
// Notes:   read data straight from the storage flops
module word_buffer #(
   parameter int W     = 32,
   parameter int DEPTH = 2
) (
   input  wire logic  clk_sys,
   input  wire logic  rst,
   input  wire logic  ce,
   word_stream_if.snk wr,
   word_stream_if.src rd
);
   localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("word_buffer: DEPTH must be a power of two of at least 2");
   end

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;
   wire          push = wr.valid && wr.ready;
   wire          pop  = rd.valid && rd.ready;
   wire  [AW:0]  fill = wp_q - rp_q;

   assign wr.ready = fill != (AW + 1)'(DEPTH);
   assign rd.valid = fill != '0;
   assign rd.data  = mem_q[rp_q[AW-1:0]];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
      end else if (ce) begin
         if (push) begin
            mem_q[wp_q[AW-1:0]] <= wr.data;
            wp_q                <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

/* File: testbench/cfg_far_model.sv */
// Purpose: host and serial memory on the far side of the loader
// Assumes: host clock period 160 ns, words handed in by the bench
// Notes:   sent_tgl flips once for each word put on the pins
module cfg_far_model (
   input  wire logic        go,
   input  wire logic [3:0]  n_ratio,
   input  wire logic [31:0] host_word,
   input  wire logic        status_line,
   input  wire logic        load_complete,
   input  wire logic        memory_select_n,
   input  wire logic        load_clock_out,
   output logic             load_clock_in,
   output logic [31:0]      load_data,
   output wire logic [3:0]  quad_serial_data,
   output logic             user_clock,
   output logic             sent_tgl
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] nib = 4'h0;
   // four bits a clock; deselected lines show the inverse
   // count of memory clock falls, so order and alignment of bits matter
   assign quad_serial_data = memory_select_n ? ~nib : nib;
   always @(negedge load_clock_out or posedge memory_select_n)
      nib <= memory_select_n ? 4'h0 : nib + 4'h1;
   initial begin
      load_clock_in = 1'b0;
      load_data = 32'h0;
      sent_tgl = 1'b0;
      forever begin
         wait (go === 1'b1);
         // first rise 2 us after status high
         wait (status_line === 1'b1);
         #2000;
         while (load_complete !== 1'b1) begin
            // word on the pins before its rise
            load_data = host_word;
            sent_tgl = ~sent_tgl;
            // word held n_ratio periods of 160 ns
            repeat (n_ratio) if (load_complete !== 1'b1) begin
               #40 load_clock_in = 1'b1;
               #80 load_clock_in = 1'b0;
               #40;
            end
         end
         repeat (2) begin
            #80 load_clock_in = 1'b1;
            #80 load_clock_in = 1'b0;
         end
         wait (go === 1'b0);
      end
   end
   // user clock only 4 host periods after load-complete
   initial user_clock = 1'b0;
   always begin
      wait (load_complete === 1'b1);
      #640;
      while (load_complete === 1'b1)
         #20 user_clock = ~user_clock;
   end
endmodule

/* File: testbench/cfg_load_sequencer_tb.sv */
// Purpose: self-checking bench of the configuration-load sequencer
// Assumes: shortened status and init counts, four words a load
// Notes:   whoever drives a word queues it; the monitor pops on output
module cfg_load_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SMIN = 300;
   localparam int SMAX = 400;
   localparam int INIT = 10;
   localparam int UEDG = 8;
   localparam int NW   = 4;
   // mode, ratio, user clock init, chain, speed
   localparam logic [9:0] RUNS [6] = '{
      {2'h0, 4'h4, 2'h0, 2'h0}, {2'h0, 4'h8, 2'h2, 2'h0}, {2'h0, 4'h1, 2'h0, 2'h0},
      {2'h1, 4'h1, 2'h0, 2'h2}, {2'h2, 4'h1, 2'h3, 2'h3}, {2'h2, 4'h1, 2'h0, 2'h1}};
   localparam int HALF [4] = '{5, 3, 2, 1};
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        config_req_n = 1'b1;
   logic [1:0]  load_mode = 2'h0;
   logic [3:0]  ratio = 4'h1;
   logic        init_from_user_clk = 1'b0;
   logic        init_done_enable = 1'b0;
   logic        chain_mode = 1'b0;
   logic [1:0]  as_speed = 2'h0;
   logic        out_ready = 1'b0;
   logic        go = 1'b0;
   logic [31:0] host_word = 32'h0;
   logic [31:0] exp_q[$];
   int          seed = 34;
   int          n_fail = 0;
   int          compares = 0;
   wire logic   status_in, status_out, status_oe, load_complete, init_done_oe, user_mode;
   wire logic   user_clock, load_clock_in, load_clock_out, memory_select_n;
   wire logic   out_valid, overrun, sent_tgl;
   wire logic [31:0] load_data, out_data;
   wire logic [3:0]  quad_serial_data;

   always #4 clk_sys = ~clk_sys;
   // open-drain status line with pull-up
   assign status_in = status_oe ? status_out : 1'b1;

   cfg_load_sequencer #(.STATUS_MIN(SMIN), .STATUS_MAX(SMAX), .INIT_CYC(INIT),
      .USER_EDGES(UEDG), .CFG_WORDS(NW)) cfg_load_sequencer_inst (
      .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .config_req_n(config_req_n),
      .status_in(status_in), .status_out(status_out), .status_oe(status_oe),
      .load_complete(load_complete), .init_done_out(), .init_done_oe(init_done_oe),
      .user_mode(user_mode), .load_mode(load_mode), .ratio(ratio),
      .init_from_user_clk(init_from_user_clk), .init_done_enable(init_done_enable),
      .chain_mode(chain_mode), .as_speed(as_speed), .user_clock(user_clock),
      .load_clock_in(load_clock_in), .load_clock_out(load_clock_out), .load_clock_oe(),
      .load_data(load_data), .memory_select_n(memory_select_n), .serial_data_line0(),
      .serial_data_line0_oe(), .quad_serial_data(quad_serial_data), .out_data(out_data),
      .out_valid(out_valid), .out_ready(out_ready), .overrun(overrun));

   cfg_far_model cfg_far_model_inst (
      .go(go), .n_ratio(ratio), .host_word(host_word), .status_line(status_in),
      .load_complete(load_complete), .memory_select_n(memory_select_n),
      .load_clock_out(load_clock_out),
      .load_clock_in(load_clock_in), .load_data(load_data),
      .quad_serial_data(quad_serial_data), .user_clock(user_clock), .sent_tgl(sent_tgl));

   // ----------------------------------------
   // checking
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic tmo(input int k, input int lim);
      check(k < lim, 1'b1);
      if (k >= lim)
         results();
   endtask
   always @(sent_tgl) if ($time > 0) begin
      exp_q.push_back(host_word);
      host_word <= $random(seed);
   end
   // receiver stalls at random
   always @(posedge clk_sys) begin
      out_ready <= 1'($random(seed));
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0)
            check(1'b1, 1'b0);
         else
            check(out_data, exp_q.pop_front());
      end
   end

   // ----------------------------------------
   // one load from request to user mode
   // ----------------------------------------
   task automatic run_cfg(input logic [9:0] c);
      int k;
      int w;
      int sp;
      logic ide;
      ide = 1'($random(seed));
      sp = (c[1:0] == 2'h3 && c[2]) ? 2 : int'(c[1:0]);
      load_mode <= c[9:8];
      ratio <= c[7:4];
      init_from_user_clk <= c[3];
      chain_mode <= c[2];
      as_speed <= c[1:0];
      init_done_enable <= ide;
      // request held 2 us, answer long due
      config_req_n <= 1'b0;
      repeat (250) @(posedge clk_sys);
      check(status_oe, 1'b1);
      check(load_complete, 1'b0);
      check(user_mode, 1'b0);
      config_req_n <= 1'b1;
      go <= (c[9:8] == 2'h0);
      if (c[9:8] != 2'h0)
         // first data fall is the 33rd, when the memory shows count 32
         for (w = 0; w < NW; w++)
            exp_q.push_back(c[9] ? (w[0] ? 32'h89AB_CDEF : 32'h0123_4567) : 32'h3333_3333);
      repeat (40) @(posedge clk_sys);
      check(status_oe, 1'b1);
      for (k = 0; k < SMAX && status_oe !== 1'b0; k++) @(posedge clk_sys);
      tmo(k, SMAX);
      if (c[9:8] != 2'h0) begin
         for (k = 0; k < 99 && load_clock_out !== 1'b1; k++) @(posedge clk_sys);
         for (w = 0; w < 99 && load_clock_out === 1'b1; w++) @(posedge clk_sys);
         check(w, HALF[sp]);
      end
      for (k = 0; k < 9999 && load_complete !== 1'b1; k++) @(posedge clk_sys);
      tmo(k, 9999);
      check(init_done_oe, ide);
      for (k = 0; k < 999 && user_mode !== 1'b1; k++) @(posedge clk_sys);
      tmo(k, 999);
      if (c[3])
         check(k >= 75 + 5 * UEDG, 1'b1);
      else
         check(k >= INIT && k <= INIT + 80, 1'b1);
      check(init_done_oe, 1'b0);
      for (k = 0; k < 99 && exp_q.size() != 0; k++) @(posedge clk_sys);
      tmo(k, 99);
      check(overrun, 1'b0);
      go <= 1'b0;
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check(status_oe, 1'b1);
      check(load_complete, 1'b0);
      foreach (RUNS[i])
         run_cfg(RUNS[i]);
      results();
   end
endmodule
